/* File: mcad_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcad_cfg.svh"
// Behaviour
// - Overflow is carry-in XOR carry-out of MSB
// - Zero flag when ALU result is zero
// - Up shift drives MSBs, down shift receives
// - Port A/B selects; B names write target
// - 256-word slow file, Y in, X out
// - Four-bit stack pointer, independent step, read-write
// - Sixteen eight-bit high address bytes on X
// - Byte index bit, selectable as carry-in
// - Even, odd, front bytes; two-bit state
// - Eight four-bit link registers from control flow
// - Page flag is low-byte carry XOR function bit2
// - Mapped page flag low on memref cycle1 while the page flag is set
// - Memory bit: address, write, read by phase
// - Front byte or nibble to low X, rest zero
// - Three interrupt requests merge into one
// - Rotator turns Y left 0/4/8/12 into X
// - Constants on low X, upper bits zero
// - R and S operand and destination routing
// - Three arithmetic, five logical functions
// - Y bus shows F or port A
// - Fetch buffer and high bytes load from X
// - All registers update on processor clock
module mcad_top #(
   parameter int SLOW_DEPTH = `MCAD_SLOW_DEPTH
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   // Microinstruction fields
   input  wire logic [3:0]  port_a_select_in,
   input  wire logic [3:0]  port_b_select_in,
   input  wire logic [2:0]  alu_function_field_in,
   input  wire logic [2:0]  alu_source_field_in,
   input  wire logic [1:0]  alu_dest_field_in,
   input  wire logic        shift_deposit_ctl_in,
   input  wire logic [1:0]  carry_sel_in,
   input  wire logic [3:0]  second_function_field_in,
   input  wire logic [3:0]  third_function_field_in,
   input  wire logic [2:0]  x_source_sel_in,
   input  wire logic        y_out_enable_in,
   // Shift line inputs for down shifts
   input  wire logic        q_shift_in,
   input  wire logic        r_shift_in,
   // Register file controls
   input  wire logic [7:0]  slow_addr_in,
   input  wire logic        slow_use_stack_in,
   input  wire logic        slow_write_in,
   input  wire logic        slow_read_in,
   input  wire logic [3:0]  high_addr_in,
   input  wire logic        high_write_in,
   input  wire logic        stack_push_in,
   input  wire logic        stack_pop_in,
   input  wire logic        stack_load_in,
   input  wire logic        byte_index_load_in,
   input  wire logic        byte_index_value_in,
   input  wire logic [2:0]  link_sel_in,
   input  wire logic        link_write_in,
   input  wire logic [3:0]  link_flow_bits_in,
   // Fetch buffer controls
   input  wire logic        fetch_write_in,
   input  wire logic        fetch_take_byte_in,
   input  wire logic        fetch_take_word_in,
   input  wire logic        low_x_front_read_n_in,
   input  wire logic        front_nibble_in,
   // Memory sequencing
   input  wire logic        mem_bit_in,
   input  wire logic [1:0]  cycle_phase_in,
   input  wire logic        mem_ref_in,
   input  wire logic [15:0] memory_read_word_in,
   // Interrupt sources
   input  wire logic        irq_emu_in,
   input  wire logic        irq_io_in,
   input  wire logic        irq_timer_in,
   // Buses and flags
   output logic [15:0] y_bus_out,
   output logic [15:0] x_bus_out,
   output logic        overflow_out,
   output logic        result_zero_flag_out,
   output logic        carry_out,
   output logic        f_msb_out,
   output logic        q_shift_out,
   output logic        q_shift_oe_n_out,
   output logic        r_shift_out,
   output logic        r_shift_oe_n_out,
   output logic        page_carry_flag_out,
   output logic        mapped_page_flag_n_out,
   output logic        memory_address_load_out,
   output logic        memory_write_load_out,
   output logic        memory_read_out,
   output logic        interrupt_out,
   // Visible state
   output logic [3:0]  stack_pointer_out,
   output logic        byte_index_bit_out,
   output logic [1:0]  fetch_buffer_state_out,
   output logic [3:0]  link_value_out
);
   // ****
   // State
   // ****
   logic [15:0] rf_q [16];
   logic [15:0] q_q;
   logic [3:0]  stack_pointer_q;
   logic        byte_index_bit_q;
   logic [7:0]  fetch_byte_regs_q [2];
   logic [7:0]  fetch_shuffle_byte_q;
   mcad_pkg::mcad_fb_state_t fetch_buffer_state_q;
   mcad_pkg::mcad_fb_state_t fetch_buffer_state_d;
   logic [3:0]  link_q [`MCAD_LINK_DEPTH];
   logic [15:0] slow_rdata;
   logic [7:0]  high_rdata;

   // ****
   // Operand selection
   // ****
   wire [15:0] port_a = rf_q[port_a_select_in];
   wire [15:0] port_b = rf_q[port_b_select_in];
   logic [15:0] x_bus;
   wire [2:0] as = alu_source_field_in;
   wire [15:0] r_op = (as == `MCAD_AS_AQ || as == `MCAD_AS_AB) ? port_a :
                      (as >= `MCAD_AS_DA) ? x_bus : 16'h0000;
   wire [15:0] s_op = (as == `MCAD_AS_AQ || as == `MCAD_AS_ZQ ||
                       as == `MCAD_AS_DQ) ? q_q :
                      (as == `MCAD_AS_AB || as == `MCAD_AS_ZB) ? port_b :
                      (as == `MCAD_AS_ZA || as == `MCAD_AS_DA) ? port_a : 16'h0000;
   wire cin = (carry_sel_in == `MCAD_CI_ONE)  ? 1'b1 :
              (carry_sel_in == `MCAD_CI_BIDX) ? byte_index_bit_q : 1'b0;

   // ****
   // ALU
   // ****
   wire [2:0]  af    = alu_function_field_in;
   wire [15:0] add_r = (af == `MCAD_AF_SUBR) ? ~r_op : r_op;
   wire [15:0] add_s = (af == `MCAD_AF_SUBS) ? ~s_op : s_op;
   wire [16:0] sum   = {1'b0, add_r} + {1'b0, add_s} + {16'h0000, cin};
   wire [15:0] low15 = {1'b0, add_r[14:0]} + {1'b0, add_s[14:0]} + {15'h0000, cin};
   wire [8:0]  low8  = {1'b0, add_r[7:0]} + {1'b0, add_s[7:0]} + {8'h00, cin};
   wire        arith = (af == `MCAD_AF_ADD) || (af == `MCAD_AF_SUBR) ||
                       (af == `MCAD_AF_SUBS);
   logic [15:0] f_out;
   always_comb begin
      case (af)
         `MCAD_AF_OR:   f_out = r_op | s_op;
         `MCAD_AF_AND:  f_out = r_op & s_op;
         `MCAD_AF_NAND: f_out = ~r_op & s_op;
         `MCAD_AF_XOR:  f_out = r_op ^ s_op;
         `MCAD_AF_XNOR: f_out = ~r_op ^ s_op;
         default:       f_out = sum[15:0];
      endcase
   end
   wire c_msb_in = arith & low15[15];
   wire c_out    = arith & sum[16];
   wire page_carry = arith & low8[8];

   assign overflow_out         = c_msb_in ^ c_out;
   assign result_zero_flag_out = (f_out == 16'h0000);
   assign carry_out            = c_out;
   assign f_msb_out            = f_out[15];
   assign page_carry_flag_out  = page_carry ^ af[2];
   assign mapped_page_flag_n_out = ~(mem_ref_in & mem_bit_in &
                                     (cycle_phase_in == `MCAD_PH1) &
                                     page_carry_flag_out);

   // ****
   // Shifter and destinations
   // ****
   wire shift_up = shift_deposit_ctl_in && (alu_dest_field_in == `MCAD_AD_SH_UP);
   assign q_shift_out      = q_q[15];
   assign r_shift_out      = f_out[15];
   assign q_shift_oe_n_out = ~shift_up;
   assign r_shift_oe_n_out = ~shift_up;
   wire [15:0] r_wdata = !shift_deposit_ctl_in ? f_out :
                         shift_up ? {f_out[14:0], 1'b0} : {r_shift_in, f_out[15:1]};
   wire [15:0] q_wdata = !shift_deposit_ctl_in ? f_out :
                         shift_up ? {q_q[14:0], 1'b0} : {q_shift_in, q_q[15:1]};
   wire r_we = (alu_dest_field_in == `MCAD_AD_RAMA) ||
               (alu_dest_field_in == `MCAD_AD_RAMF) || shift_deposit_ctl_in;
   wire q_we = shift_deposit_ctl_in || (alu_dest_field_in == `MCAD_AD_QREG);
   wire [15:0] y_bus = (!shift_deposit_ctl_in &&
                        alu_dest_field_in == `MCAD_AD_RAMA) ? port_a : f_out;
   assign y_bus_out = y_out_enable_in ? y_bus : 16'h0000;

   always_ff @(posedge clk_sys_in) begin
      if (r_we) begin
         rf_q[port_b_select_in] <= r_wdata;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         q_q <= 16'h0000;
      end else if (q_we) begin
         q_q <= q_wdata;
      end
   end

   // ****
   // X bus sources
   // ****
   wire [1:0]  rot = third_function_field_in[1:0];
   wire [15:0] rot_y = (rot == 2'h1) ? {y_bus[11:0], y_bus[15:12]} :
                       (rot == 2'h2) ? {y_bus[7:0], y_bus[15:8]} :
                       (rot == 2'h3) ? {y_bus[3:0], y_bus[15:4]} : y_bus;
   wire [15:0] front_x = front_nibble_in ? {12'h000, fetch_shuffle_byte_q[3:0]} :
                                           {8'h00, fetch_shuffle_byte_q};
   always_comb begin
      if (!low_x_front_read_n_in) begin
         x_bus = front_x;
      end else begin
         case (x_source_sel_in)
            `MCAD_XS_SLOW:  x_bus = slow_rdata;
            `MCAD_XS_HIGH:  x_bus = {8'h00, high_rdata};
            `MCAD_XS_ROT:   x_bus = rot_y;
            `MCAD_XS_K4:    x_bus = {12'h000, third_function_field_in};
            `MCAD_XS_K8:    x_bus = {8'h00, second_function_field_in,
                                     third_function_field_in};
            `MCAD_XS_FRONT: x_bus = {8'h00, fetch_shuffle_byte_q};
            `MCAD_XS_MEM:   x_bus = memory_read_word_in;
            default:        x_bus = 16'h0000;
         endcase
      end
   end
   assign x_bus_out = x_bus;

   // ****
   // Slow file, high bytes, stack, byte index, links
   // ****
   wire [7:0] slow_addr = slow_use_stack_in ? {4'h0, stack_pointer_q} : slow_addr_in;
   wire slow_we = slow_write_in & ~slow_read_in;
   mcad_ram #(.WIDTH(16), .DEPTH(SLOW_DEPTH), .AW(8)) u_slow (
      .clk_sys_in (clk_sys_in),
      .we_in      (slow_we),
      .waddr_in   (slow_addr),
      .wdata_in   (y_bus),
      .raddr_in   (slow_addr),
      .rdata_out  (slow_rdata)
   );
   mcad_ram #(.WIDTH(8), .DEPTH(`MCAD_HIGH_DEPTH), .AW(4)) u_high (
      .clk_sys_in (clk_sys_in),
      .we_in      (high_write_in),
      .waddr_in   (high_addr_in),
      .wdata_in   (x_bus[7:0]),
      .raddr_in   (high_addr_in),
      .rdata_out  (high_rdata)
   );
   wire [3:0] stack_step = stack_push_in && !stack_pop_in ? 4'h1 :
                           stack_pop_in && !stack_push_in ? 4'hF : 4'h0;
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         stack_pointer_q  <= `MCAD_RST_STACK;
         byte_index_bit_q <= 1'b0;
      end else begin
         if (stack_load_in) begin
            stack_pointer_q <= y_bus[3:0];
         end else begin
            stack_pointer_q <= stack_pointer_q + stack_step;
         end
         if (byte_index_load_in) begin
            byte_index_bit_q <= byte_index_value_in;
         end
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < `MCAD_LINK_DEPTH; i++) begin
            link_q[i] <= 4'h0;
         end
      end else if (link_write_in) begin
         link_q[link_sel_in] <= link_flow_bits_in;
      end
   end
   assign link_value_out     = link_q[link_sel_in];
   assign stack_pointer_out  = stack_pointer_q;
   assign byte_index_bit_out = byte_index_bit_q;

   // ****
   // Fetch buffer
   // ****
   always_comb begin
      fetch_buffer_state_d = fetch_buffer_state_q;
      if (fetch_write_in) begin
         fetch_buffer_state_d = mcad_pkg::MCAD_FB_FULL;
      end else if (fetch_take_word_in) begin
         fetch_buffer_state_d = mcad_pkg::MCAD_FB_EMPTY;
      end else if (fetch_take_byte_in) begin
         case (fetch_buffer_state_q)
            mcad_pkg::MCAD_FB_FULL: fetch_buffer_state_d = mcad_pkg::MCAD_FB_WORD;
            mcad_pkg::MCAD_FB_WORD: fetch_buffer_state_d = mcad_pkg::MCAD_FB_BYTE;
            default:                fetch_buffer_state_d = mcad_pkg::MCAD_FB_EMPTY;
         endcase
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
         fetch_buffer_state_q <= mcad_pkg::MCAD_FB_EMPTY;
         fetch_byte_regs_q[0] <= 8'h00;
         fetch_byte_regs_q[1] <= 8'h00;
         fetch_shuffle_byte_q <= 8'h00;
      end else begin
         fetch_buffer_state_q <= fetch_buffer_state_d;
         if (fetch_write_in) begin
            fetch_byte_regs_q[0] <= x_bus[15:8];
            fetch_byte_regs_q[1] <= x_bus[7:0];
            fetch_shuffle_byte_q <= x_bus[15:8];
         end else if (fetch_take_byte_in) begin
            fetch_shuffle_byte_q <= fetch_byte_regs_q[1];
         end
      end
   end
   assign fetch_buffer_state_out =
      (fetch_buffer_state_q == mcad_pkg::MCAD_FB_BYTE) ? 2'h1 :
      (fetch_buffer_state_q == mcad_pkg::MCAD_FB_WORD) ? 2'h2 :
      (fetch_buffer_state_q == mcad_pkg::MCAD_FB_FULL) ? 2'h3 : 2'h0;

   // ****
   // Memory strobes and interrupt
   // ****
   assign memory_address_load_out = mem_bit_in && (cycle_phase_in == `MCAD_PH1);
   assign memory_write_load_out   = mem_bit_in && (cycle_phase_in == `MCAD_PH2);
   assign memory_read_out         = mem_bit_in && (cycle_phase_in == `MCAD_PH3);
   assign interrupt_out = irq_emu_in | irq_io_in | irq_timer_in;

   // ****
   // Checks
   // ****
   property p_ovf;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (af == `MCAD_AF_ADD) |->
         overflow_out == ((add_r[15] == add_s[15]) && (f_out[15] != add_r[15]));
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow wrong");
   property p_zero;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      result_zero_flag_out |-> (f_out == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_qwr;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (alu_dest_field_in == `MCAD_AD_QREG && !shift_deposit_ctl_in) |=>
         q_q == $past(f_out);
   endproperty
   a_qwr: assert property (p_qwr) else $error("Q not loaded");
   property p_sp;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (stack_push_in && !stack_pop_in && !stack_load_in) |=>
         stack_pointer_q == $past(stack_pointer_q) + 4'h1;
   endproperty
   a_sp: assert property (p_sp) else $error("push did not step");
   property p_map;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !mapped_page_flag_n_out |-> (mem_bit_in && cycle_phase_in == `MCAD_PH1);
   endproperty
   a_map: assert property (p_map) else $error("mapped flag off phase");
   property p_fb;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      fetch_write_in |=> fetch_buffer_state_out == 2'h3;
   endproperty
   a_fb: assert property (p_fb) else $error("buffer not full");
   property p_front;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !low_x_front_read_n_in |-> x_bus[15:8] == 8'h00;
   endproperty
   a_front: assert property (p_front) else $error("upper X not zero");
   property p_irq;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      irq_timer_in |-> interrupt_out;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt lost");
endmodule
`default_nettype wire

/* File: mcad_cfg.svh */
`ifndef MCAD_CFG_SVH
`define MCAD_CFG_SVH
// ****
// Widths and encodings
// ****
`define MCAD_CLK_PERIOD_NS 125
`define MCAD_SLOW_DEPTH    256
`define MCAD_HIGH_DEPTH    16
`define MCAD_LINK_DEPTH    8
// ALU function codes
`define MCAD_AF_ADD   3'h0
`define MCAD_AF_SUBR  3'h1
`define MCAD_AF_SUBS  3'h2
`define MCAD_AF_OR    3'h3
`define MCAD_AF_AND   3'h4
`define MCAD_AF_NAND  3'h5
`define MCAD_AF_XOR   3'h6
`define MCAD_AF_XNOR  3'h7
// ALU source codes (R,S)
`define MCAD_AS_AQ 3'h0
`define MCAD_AS_AB 3'h1
`define MCAD_AS_ZQ 3'h2
`define MCAD_AS_ZB 3'h3
`define MCAD_AS_ZA 3'h4
`define MCAD_AS_DA 3'h5
`define MCAD_AS_DQ 3'h6
`define MCAD_AS_DZ 3'h7
// Destination codes
`define MCAD_AD_QREG   2'h0
`define MCAD_AD_NOP    2'h1
`define MCAD_AD_RAMA   2'h2
`define MCAD_AD_RAMF   2'h3
// Shift direction while shift_deposit_ctl is high
`define MCAD_AD_SH_UP  2'h0
// Carry-in select
`define MCAD_CI_ZERO 2'h0
`define MCAD_CI_ONE  2'h1
`define MCAD_CI_BIDX 2'h2
// X bus source select
`define MCAD_XS_NONE  3'h0
`define MCAD_XS_SLOW  3'h1
`define MCAD_XS_HIGH  3'h2
`define MCAD_XS_ROT   3'h3
`define MCAD_XS_K4    3'h4
`define MCAD_XS_K8    3'h5
`define MCAD_XS_FRONT 3'h6
`define MCAD_XS_MEM   3'h7
// Memory-bit phase codes
`define MCAD_PH1 2'h1
`define MCAD_PH2 2'h2
`define MCAD_PH3 2'h3
`define MCAD_RST_STACK 4'h0
`endif

/* File: mcad_pkg.sv */
package mcad_pkg;
   typedef enum logic [3:0] {
      MCAD_FB_EMPTY = 4'h1,
      MCAD_FB_BYTE  = 4'h2,
      MCAD_FB_WORD  = 4'h4,
      MCAD_FB_FULL  = 4'h8
   } mcad_fb_state_t;
endpackage

/* File: mcad_ram.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// One-write, one-read memory with registered read data
// ****
module mcad_ram #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock
   input  wire logic             clk_sys_in,
   // Write
   input  wire logic             we_in,
   input  wire logic [AW-1:0]    waddr_in,
   input  wire logic [WIDTH-1:0] wdata_in,
   // Read
   input  wire logic [AW-1:0]    raddr_in,
   output logic      [WIDTH-1:0] rdata_out
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule
`default_nettype wire

/* File: mcad_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****
// Memory side of the controller: address, write and read by phase
// ****
module mcad_mem_model #(
   parameter logic [15:0] INIT [0:3] = '{default: 16'h0}
) (
   // Clock
   input  wire logic        clk_sys_in,
   // Phase strobes and data from the datapath
   input  wire logic        addr_load_in,
   input  wire logic        write_load_in,
   input  wire logic        read_in,
   input  wire logic [15:0] y_bus_in,
   // Read data to the datapath
   output logic      [15:0] read_word_out
);
   logic [15:0] mem_q [0:3];
   logic [1:0]  addr_q;
   logic [15:0] last_q;
   initial begin
      mem_q = INIT;
      addr_q = 2'h0;
      last_q = 16'h0;
   end
   always @(posedge clk_sys_in) begin
      if (addr_load_in)
         addr_q <= y_bus_in[1:0];
      if (write_load_in)
         mem_q[addr_q] <= y_bus_in;
      if (read_in) begin
         addr_q <= addr_q + 2'h1;
         last_q <= mem_q[addr_q];
      end
   end
   // Outside a read the line shows the complement of the last word read
   assign read_word_out = read_in ? mem_q[addr_q] : ~last_q;
endmodule
`default_nettype wire

/* File: mcad_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "mcad_cfg.svh"
module mcad_top_bench;
   localparam logic [15:0] MEMV [0:3] = '{16'h7FFF, 16'h0001, 16'h8000, 16'h00FF};
   localparam logic [2:0]  SOP [0:5]  = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
   localparam logic [3:0]  SEXP [0:5] = '{4'h1, 4'h2, 4'h1, 4'h1, 4'hF, 4'h0};
   logic        clk_sys_in, rst_b_in, shift_deposit_ctl_in, y_out_enable_in, q_shift_in;
   logic [3:0]  port_a_select_in, port_b_select_in, second_function_field_in;
   logic [3:0]  third_function_field_in, high_addr_in, link_flow_bits_in;
   logic [2:0]  alu_function_field_in, alu_source_field_in, x_source_sel_in, link_sel_in;
   logic [1:0]  alu_dest_field_in, carry_sel_in, cycle_phase_in, fetch_buffer_state_out;
   logic [7:0]  slow_addr_in;
   logic        r_shift_in, slow_use_stack_in, slow_write_in, slow_read_in, high_write_in;
   logic        stack_push_in, stack_pop_in, stack_load_in, byte_index_load_in;
   logic        byte_index_value_in, link_write_in, fetch_write_in, fetch_take_byte_in;
   logic        fetch_take_word_in, low_x_front_read_n_in, front_nibble_in, mem_bit_in;
   logic        mem_ref_in, irq_emu_in, irq_io_in, irq_timer_in;
   logic [15:0] memory_read_word_in, y_bus_out, x_bus_out;
   logic        overflow_out, result_zero_flag_out, carry_out, f_msb_out, q_shift_out;
   logic        q_shift_oe_n_out, r_shift_out, r_shift_oe_n_out, page_carry_flag_out;
   logic        mapped_page_flag_n_out, memory_address_load_out, memory_write_load_out;
   logic        memory_read_out, interrupt_out, byte_index_bit_out;
   logic [3:0]  stack_pointer_out, link_value_out;
   logic [18:0] e;
   logic [31:0] rot;
   int          n_fail, compares;
   // ****
   // Design and memory side
   // ****
   mcad_top mcad_top_inst (.*);
   mcad_mem_model #(.INIT(MEMV)) mcad_mem_model_inst (
      .clk_sys_in(clk_sys_in), .addr_load_in(memory_address_load_out),
      .write_load_in(memory_write_load_out), .read_in(memory_read_out),
      .y_bus_in(y_bus_out), .read_word_out(memory_read_word_in));
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // ****
   // Tasks
   // ****
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk_w({15'h0, got}, {15'h0, exp});
   endtask
   // {carry out, carry into msb, low byte carry, result}
   function automatic logic [18:0] alu_exp(input logic [2:0] f, input logic [15:0] r, s,
                                           input logic c);
      logic [15:0] a, b;
      logic [16:0] t, lo;
      logic [8:0]  p;
      a = (f == `MCAD_AF_SUBR) ? ~r : r;
      b = (f == `MCAD_AF_SUBS) ? ~s : s;
      t = {1'b0, a} + {1'b0, b} + {16'h0, c};
      lo = {2'h0, a[14:0]} + {2'h0, b[14:0]} + {16'h0, c};
      p = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h0, c};
      case (f)
         3'h3: t[15:0] = r | s;
         3'h4: t[15:0] = r & s;
         3'h5: t[15:0] = ~r & s;
         3'h6: t[15:0] = r ^ s;
         3'h7: t[15:0] = ~r ^ s;
         default: ;
      endcase
      return {t[16], lo[15], p[8], t[15:0]};
   endfunction
   task automatic defaults();
      {port_a_select_in, port_b_select_in} = 8'h0;
      {second_function_field_in, third_function_field_in} = 8'h0;
      {alu_source_field_in, alu_function_field_in} = {`MCAD_AS_ZA, `MCAD_AF_OR};
      {alu_dest_field_in, carry_sel_in, x_source_sel_in} = {`MCAD_AD_NOP, 5'h0};
      {shift_deposit_ctl_in, q_shift_in, r_shift_in, slow_use_stack_in, slow_write_in} = 5'h0;
      {slow_read_in, high_write_in, stack_push_in, stack_pop_in, stack_load_in} = 5'h0;
      {byte_index_load_in, byte_index_value_in, link_write_in, fetch_write_in} = 4'h0;
      {fetch_take_byte_in, fetch_take_word_in, front_nibble_in, mem_bit_in, mem_ref_in} = 5'h0;
      {irq_emu_in, irq_io_in, irq_timer_in, low_x_front_read_n_in, y_out_enable_in} = 5'h3;
      {slow_addr_in, high_addr_in, link_sel_in, link_flow_bits_in, cycle_phase_in} = 21'h0;
   endtask
   task automatic st();
      @(negedge clk_sys_in);
      defaults();
   endtask
   task automatic tick();
      @(posedge clk_sys_in);
      #1;
   endtask
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (1000) @(posedge clk_sys_in);
      n_fail++;
      end_of_test();
   end
   // ****
   // Tests
   // ****
   initial begin
      n_fail = 0;
      compares = 0;
      rst_b_in = 1'b0;
      defaults();
      repeat (5) @(posedge clk_sys_in);
      st();
      rst_b_in = 1'b1;
      #1;
      chk_w({9'h0, stack_pointer_out, byte_index_bit_out, fetch_buffer_state_out}, 16'h0);
      for (int i = 0; i < 4; i++) begin
         st();
         {x_source_sel_in, alu_source_field_in} = {`MCAD_XS_MEM, `MCAD_AS_DZ};
         {alu_dest_field_in, port_b_select_in} = {`MCAD_AD_RAMF, 4'(i + 1)};
         {mem_bit_in, cycle_phase_in} = {1'b1, `MCAD_PH3};
         #1;
         chk_w(y_bus_out, MEMV[i]);
      end
      for (int k = 0; k < 32; k++) begin
         st();
         {alu_source_field_in, alu_function_field_in} = {`MCAD_AS_AB, k[2:0]};
         {port_a_select_in, port_b_select_in} = {(k[4] ? 4'h2 : 4'h1), 4'h2};
         carry_sel_in = {1'b0, k[3]};
         #1;
         e = alu_exp(k[2:0], MEMV[k[4] ? 1 : 0], MEMV[1], k[3]);
         chk_w(y_bus_out, e[15:0]);
         chk_b(result_zero_flag_out, e[15:0] == 16'h0);
         chk_b(f_msb_out, e[15]);
         chk_b(mapped_page_flag_n_out, 1'b1);
         if (k[2:0] < 3'h3) begin
            chk_b(overflow_out, e[18] ^ e[17]);
            chk_b(carry_out, e[18]);
            chk_b(page_carry_flag_out, e[16]);
         end
      end
      st();
      {byte_index_load_in, byte_index_value_in} = 2'h3;
      tick();
      chk_b(byte_index_bit_out, 1'b1);
      st();
      {alu_source_field_in, alu_function_field_in} = {`MCAD_AS_AB, `MCAD_AF_ADD};
      {port_a_select_in, port_b_select_in, carry_sel_in} = {8'h22, `MCAD_CI_BIDX};
      #1;
      chk_w(y_bus_out, 16'h0003);
      for (int i = 0; i < 6; i++) begin
         st();
         port_a_select_in = 4'h4;
         {stack_load_in, stack_pop_in, stack_push_in} = SOP[i];
         tick();
         chk_w({12'h0, stack_pointer_out}, {12'h0, SEXP[i]});
      end
      st();
      {port_a_select_in, slow_addr_in, slow_write_in} = {4'h1, 8'hFF, 1'b1};
      st();
      {port_a_select_in, slow_addr_in, slow_write_in} = {4'h2, 8'h00, 1'b1};
      st();
      {port_a_select_in, slow_addr_in, slow_write_in, slow_read_in} = {4'h1, 8'h00, 2'h3};
      st();
      {slow_addr_in, slow_read_in} = {8'hFF, 1'b1};
      st();
      {slow_addr_in, slow_read_in, x_source_sel_in} = {8'h00, 1'b1, `MCAD_XS_SLOW};
      #1;
      chk_w(x_bus_out, 16'h7FFF);
      st();
      x_source_sel_in = `MCAD_XS_SLOW;
      #1;
      chk_w(x_bus_out, 16'h0001);
      st();
      {port_a_select_in, x_source_sel_in, high_addr_in} = {4'h4, `MCAD_XS_ROT, 4'hF};
      high_write_in = 1'b1;
      st();
      high_addr_in = 4'hF;
      st();
      {high_addr_in, x_source_sel_in} = {4'hF, `MCAD_XS_HIGH};
      #1;
      chk_w({8'h0, x_bus_out[7:0]}, 16'h00FF);
      for (int k = 0; k < 4; k++) begin
         st();
         {port_a_select_in, x_source_sel_in} = {4'h4, `MCAD_XS_ROT};
         third_function_field_in = 4'(k);
         #1;
         rot = {MEMV[3], MEMV[3]} << (4 * k);
         chk_w(x_bus_out, rot[31:16]);
      end
      st();
      alu_dest_field_in = `MCAD_AD_RAMA;
      {alu_function_field_in, port_a_select_in} = {`MCAD_AF_AND, 4'h3};
      #1;
      chk_w(y_bus_out, 16'h8000);
      for (int k = 0; k < 2; k++) begin
         st();
         {second_function_field_in, third_function_field_in} = 8'hFF;
         x_source_sel_in = k[0] ? `MCAD_XS_K8 : `MCAD_XS_K4;
         #1;
         chk_w(x_bus_out, k[0] ? 16'h00FF : 16'h000F);
      end
      st();
      {port_a_select_in, x_source_sel_in, fetch_write_in} = {4'h4, `MCAD_XS_ROT, 1'b1};
      tick();
      chk_b(fetch_buffer_state_out != 2'h0, 1'b1);
      st();
      fetch_take_byte_in = 1'b1;
      st();
      {x_source_sel_in, low_x_front_read_n_in} = {`MCAD_XS_FRONT, 1'b0};
      #1;
      chk_w(x_bus_out, 16'h00FF);
      st();
      {x_source_sel_in, low_x_front_read_n_in, front_nibble_in} = {`MCAD_XS_FRONT, 2'h1};
      #1;
      chk_w(x_bus_out, 16'h000F);
      for (int i = 0; i < 16; i++) begin
         st();
         {link_sel_in, link_write_in, link_flow_bits_in} = {i[2:0], ~i[3], i[3:0] ^ 4'hE};
         #1;
         if (i[3])
            chk_w({12'h0, link_value_out}, {13'h0, i[2:0]} ^ 16'hE);
      end
      for (int i = 0; i < 4; i++) begin
         st();
         {irq_timer_in, irq_io_in, irq_emu_in} = 3'(1 << i);
         #1;
         chk_b(interrupt_out, i < 3);
      end
      st();
      {port_a_select_in, port_b_select_in, shift_deposit_ctl_in} = {8'h35, 1'b1};
      alu_dest_field_in = `MCAD_AD_SH_UP;
      #1;
      chk_w({12'h0, r_shift_out, r_shift_oe_n_out, q_shift_out, q_shift_oe_n_out}, 16'h8);
      st();
      {port_b_select_in, shift_deposit_ctl_in, alu_dest_field_in} = {4'h5, 1'b1, 2'h1};
      {q_shift_in, r_shift_in, y_out_enable_in} = 3'h6;
      #1;
      chk_w({14'h0, r_shift_oe_n_out, q_shift_oe_n_out}, 16'h3);
      chk_w(y_bus_out, 16'h0);
      for (int p = 1; p < 4; p++) begin
         st();
         {alu_source_field_in, alu_function_field_in} = {`MCAD_AS_AB, `MCAD_AF_ADD};
         {port_a_select_in, port_b_select_in, mem_ref_in, mem_bit_in} = {8'h42, 2'h3};
         cycle_phase_in = p[1:0];
         #1;
         chk_b(page_carry_flag_out, 1'b1);
         chk_b(mapped_page_flag_n_out, p != 1);
         chk_w({13'h0, memory_address_load_out, memory_write_load_out, memory_read_out},
               16'h8 >> p);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
